// ### hdl/orrd_cfg.svh
`ifndef ORRD_CFG_SVH
`define ORRD_CFG_SVH

// cpu address map
`define ORRD_RAM_LO       16'hfb80
`define ORRD_RAM_HI       16'hff7f
`define ORRD_ROM_HI       16'h7fff
`define ORRD_RAM_CONTROL_ADDR   16'hfff9

// axi address width and register indices, byte address is index times four
`define ORRD_AXI_AW       18
`define ORRD_IDX_RAM_CONTROL    16'hfff9
`define ORRD_IDX_STATUS   16'hfff0
`define ORRD_IDX_MASK     16'hfff1
`define ORRD_IDX_INFO     16'hfff2

// ram control layout and reset
`define ORRD_RAM_CONTROL_RESET  8'hff
`define ORRD_RAM_ENABLE_BIT_BIT     7
`define ORRD_RAM_CONTROL_RSVD   7'h7f

// status bits
`define ORRD_ST_ADDR_ERR  0
`define ORRD_ST_EXT       1

// timing
`define ORRD_ACCESS_STATES 2
`define ORRD_MODE_CAP_DLY  3'h4

`endif

// ### hdl/orrd_pkg.sv
package orrd_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } orrd_cpu_req_t;

  typedef struct packed {
    logic        ack;
    logic        ext;
    logic        addr_err;
    logic [15:0] rdata;
  } orrd_cpu_rsp_t;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic [14:0] addr;
    logic [7:0]  data;
  } orrd_prom_in_t;

  typedef enum logic [2:0] {
    ORRD_RT_RAM = 3'b000,
    ORRD_RT_ROM = 3'b001,
    ORRD_RT_REG = 3'b010,
    ORRD_RT_EXT = 3'b011,
    ORRD_RT_ERR = 3'b100
  } orrd_route_t;

endpackage

// ### hdl/orrd_top.sv
// How it works
// - 1 KB ram on a 16-bit path
// - every ram access answers in two states
// - ram window fb80 through ff7f
// - 8-bit ram control at fff9, resets ff
// - bit 7 enables the ram
// - enable resets to one, standby leaves it
// - bits 6 to 0 read one, ignore writes
// - expanded modes send disabled window outside
// - single-chip disabled window raises address error
// - 32 KB rom, 16-bit, two states
// - mode pins sampled at release pick rom enable
// - programming pins halt the processor side
// - chip select and output gate pick sub-mode
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "orrd_cfg.svh"

module orrd_top
  import orrd_pkg::*;
#(
  parameter int RAM_BYTES = 1024,
  parameter int ROM_BYTES = 32768
) (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // cpu internal bus
  input  wire orrd_cpu_req_t            cpu_req,
  output logic                          cpu_ready,
  output orrd_cpu_rsp_t                 cpu_rsp,
  // pins
  input  wire logic [2:0]               mode_pins,
  input  wire logic                     standby_pin,
  input  wire logic                     port6_bit1_pin,
  input  wire logic                     port6_bit0_pin,
  input  wire orrd_prom_in_t            prom_in,
  output logic [7:0]                    prom_data_o,
  output logic                          prom_data_oe,
  output logic                          prom_mode,
  // axi4-lite slave
  input  wire logic [`ORRD_AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`ORRD_AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // interrupt
  output logic                          irq
);

  // sizes are tied to the decode windows
  if (RAM_BYTES != 1024 || ROM_BYTES != 32768) begin : g_size_check
    $error("orrd_top: memory sizes fixed by the address map");
  end

  localparam int PW = 3 + 1 + 2 + $bits(orrd_prom_in_t);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [PW-1:0] pin_s1_r;
  logic [PW-1:0] pin_s2_r;
  logic [PW-1:0] pin_s3_r;
  logic [PW-1:0] pin_flt_r;
  logic [2:0]    md_f;
  logic          standby_pin_f;
  logic          p61_f;
  logic          p60_f;
  orrd_prom_in_t prom_f;

  always_ff @(posedge aclk) begin
    pin_s1_r <= {mode_pins, standby_pin, port6_bit1_pin, port6_bit0_pin, prom_in};
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
  end

  // a bit changes once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_flt_r <= '0;
    end else begin
      pin_flt_r <= (pin_s3_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_flt_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  assign {md_f, standby_pin_f, p61_f, p60_f, prom_f} = pin_flt_r;

  // ****************************************************************
  // mode capture
  // ****************************************************************
  logic [2:0] cap_cnt_r;
  logic [2:0] mode_r;
  logic       mode_valid_r;
  logic       rom_en_r;
  logic       expanded;
  logic       single_chip;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_cnt_r    <= 3'h0;
      mode_valid_r <= 1'b0;
      mode_r       <= 3'h0;
      rom_en_r     <= 1'b0;
    end else if (!mode_valid_r) begin
      cap_cnt_r <= cap_cnt_r + 3'h1;
      if (cap_cnt_r == `ORRD_MODE_CAP_DLY) begin
        mode_valid_r <= 1'b1;
        mode_r       <= md_f;
        rom_en_r     <= (md_f == 3'b010) || (md_f == 3'b100) || (md_f == 3'b111);
      end
    end
  end

  assign expanded    = (mode_r >= 3'd1) && (mode_r <= 3'd4);
  assign single_chip = (mode_r == 3'd7);

  assign prom_mode = (md_f == 3'b000) && !standby_pin_f && p61_f && p60_f;

  // ****************************************************************
  // memories
  // ****************************************************************
  // ram and rom arrays
  logic [7:0] ram_mem [RAM_BYTES];
  logic [7:0] rom_mem [ROM_BYTES];
  logic [7:0] ram_control_r;
  logic       ram_en;

  assign ram_en = ram_control_r[`ORRD_RAM_ENABLE_BIT_BIT];

  // ****************************************************************
  // cpu access
  // ****************************************************************
  function automatic orrd_route_t route_of(input logic [15:0] a, input logic re,
                                           input logic ro, input logic sc);
    orrd_route_t r;
    r = ORRD_RT_EXT;
    if (a >= `ORRD_RAM_LO && a <= `ORRD_RAM_HI) begin
      if (re) begin
        r = ORRD_RT_RAM;
      end else if (sc) begin
        r = ORRD_RT_ERR;
      end
    end else if (a[15:1] == 15'(`ORRD_RAM_CONTROL_ADDR >> 1)) begin
      r = ORRD_RT_REG;
    end else if (a <= `ORRD_ROM_HI && ro) begin
      r = ORRD_RT_ROM;
    end
    return r;
  endfunction

  logic          busy_r;
  logic          take;
  orrd_route_t   rt;
  logic [9:0]    ram_ix;
  logic [14:0]   rom_ix;
  orrd_cpu_rsp_t rsp_r;

  assign cpu_ready = !busy_r && mode_valid_r && !prom_mode;
  assign take      = cpu_req.valid && cpu_ready;
  assign rt        = route_of(cpu_req.addr, ram_en, rom_en_r, single_chip);
  assign ram_ix    = 10'(cpu_req.addr - `ORRD_RAM_LO);
  assign rom_ix    = cpu_req.addr[14:0];
  assign cpu_rsp   = rsp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= take;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_r <= '0;
    end else begin
      rsp_r.ack      <= take;
      rsp_r.ext      <= take && (rt == ORRD_RT_EXT);
      rsp_r.addr_err <= take && (rt == ORRD_RT_ERR);
      if (take && !cpu_req.write) begin
        case (rt)
          ORRD_RT_RAM: begin
            rsp_r.rdata <= cpu_req.word ? {ram_mem[ram_ix], ram_mem[ram_ix | 10'h1]}
                                        : {8'h00, ram_mem[ram_ix]};
          end
          ORRD_RT_ROM: begin
            rsp_r.rdata <= cpu_req.word ? {rom_mem[rom_ix], rom_mem[rom_ix | 15'h1]}
                                        : {8'h00, rom_mem[rom_ix]};
          end
          ORRD_RT_REG: begin
            rsp_r.rdata <= {8'h00, ram_control_r};
          end
          default: begin
            rsp_r.rdata <= 16'h0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (take && cpu_req.write && rt == ORRD_RT_RAM) begin
      if (cpu_req.word) begin
        ram_mem[ram_ix]         <= cpu_req.wdata[15:8];
        ram_mem[ram_ix | 10'h1] <= cpu_req.wdata[7:0];
      end else begin
        ram_mem[ram_ix] <= cpu_req.wdata[7:0];
      end
    end
  end

  // ****************************************************************
  // programming mode
  // ****************************************************************
  logic prom_wr;
  logic prom_vfy;

  assign prom_wr  = prom_mode && !prom_f.ce_n && prom_f.oe_n;
  assign prom_vfy = prom_mode && prom_f.ce_n && !prom_f.oe_n;

  always_ff @(posedge aclk) begin
    if (prom_wr) begin
      rom_mem[prom_f.addr] <= prom_f.data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prom_data_o  <= 8'h00;
      prom_data_oe <= 1'b0;
    end else begin
      prom_data_o  <= rom_mem[prom_f.addr];
      prom_data_oe <= prom_vfy;
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic                    aw_have_r;
  logic                    w_have_r;
  logic [`ORRD_AXI_AW-1:0] awaddr_r;
  logic [31:0]             wdata_r;
  logic [3:0]              wstrb_r;
  logic                    wr_go;
  logic                    rd_go;
  logic [15:0]             wr_ix;
  logic [15:0]             rd_ix;
  logic [1:0]              status_r;
  logic [1:0]              mask_r;
  logic                    st_clr;

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_have_r && w_have_r;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_ix = awaddr_r[17:2];
  assign rd_ix = s_axi_araddr[17:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      awaddr_r     <= '0;
      wdata_r      <= 32'h00000000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ix == `ORRD_IDX_RAM_CONTROL || wr_ix == `ORRD_IDX_STATUS ||
                         wr_ix == `ORRD_IDX_MASK || wr_ix == `ORRD_IDX_INFO) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_control_r <= `ORRD_RAM_CONTROL_RESET;
      mask_r  <= 2'b00;
    end else begin
      if (wr_go && wr_ix == `ORRD_IDX_RAM_CONTROL && wstrb_r[0]) begin
        ram_control_r[`ORRD_RAM_ENABLE_BIT_BIT] <= wdata_r[`ORRD_RAM_ENABLE_BIT_BIT];
      end else if (take && cpu_req.write && rt == ORRD_RT_REG &&
                   (cpu_req.addr[0] || cpu_req.word)) begin
        ram_control_r[`ORRD_RAM_ENABLE_BIT_BIT] <= cpu_req.wdata[`ORRD_RAM_ENABLE_BIT_BIT];
      end
      ram_control_r[6:0] <= `ORRD_RAM_CONTROL_RSVD;
      if (wr_go && wr_ix == `ORRD_IDX_MASK && wstrb_r[0]) begin
        mask_r <= wdata_r[1:0];
      end
    end
  end

  assign st_clr = rd_go && rd_ix == `ORRD_IDX_STATUS;

  // sticky events, set beats read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 2'b00;
    end else begin
      status_r[`ORRD_ST_ADDR_ERR] <= rsp_r.addr_err | (status_r[`ORRD_ST_ADDR_ERR] & !st_clr);
      status_r[`ORRD_ST_EXT]      <= rsp_r.ext | (status_r[`ORRD_ST_EXT] & !st_clr);
    end
  end

  assign irq = |(status_r & mask_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      if (rd_ix == `ORRD_IDX_RAM_CONTROL) begin
        s_axi_rdata <= {24'h000000, ram_control_r};
      end else if (rd_ix == `ORRD_IDX_STATUS) begin
        s_axi_rdata <= {30'h00000000, status_r};
      end else if (rd_ix == `ORRD_IDX_MASK) begin
        s_axi_rdata <= {30'h00000000, mask_r};
      end else if (rd_ix == `ORRD_IDX_INFO) begin
        s_axi_rdata <= {25'h0000000, prom_mode, mode_valid_r, rom_en_r, 1'b0, mode_r};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_two_state;
    take |=> rsp_r.ack ##1 !rsp_r.ack;
  endproperty
  a_two_state: assert property (p_two_state) else $error("access not two states");

  property p_reset_val;
    $past(!aresetn) |-> ram_control_r == `ORRD_RAM_CONTROL_RESET;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("ram control reset wrong");

  property p_rsvd_ones;
    s_axi_rvalid && $past(rd_go && rd_ix == `ORRD_IDX_RAM_CONTROL) |-> s_axi_rdata[6:0] == 7'h7f;
  endproperty
  a_rsvd_ones: assert property (p_rsvd_ones) else $error("reserved bits not one");

  property p_addr_err;
    take && single_chip && !ram_en && cpu_req.addr >= `ORRD_RAM_LO &&
      cpu_req.addr <= `ORRD_RAM_HI |=> rsp_r.addr_err && rsp_r.ack;
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("no address error");

  property p_ext;
    take && expanded && !ram_en && cpu_req.addr >= `ORRD_RAM_LO &&
      cpu_req.addr <= `ORRD_RAM_HI |=> rsp_r.ext && !rsp_r.addr_err;
  endproperty
  a_ext: assert property (p_ext) else $error("window not sent outside");

  property p_rom_en;
    mode_valid_r |-> rom_en_r == (mode_r == 3'b010 || mode_r == 3'b100 || mode_r == 3'b111);
  endproperty
  a_rom_en: assert property (p_rom_en) else $error("rom enable mismatch");

  property p_halt;
    prom_mode |-> !cpu_ready ##1 !rsp_r.ack;
  endproperty
  a_halt: assert property (p_halt) else $error("cpu side active in programming");

  property p_float;
    prom_mode && prom_f.ce_n && prom_f.oe_n |=> !prom_data_oe;
  endproperty
  a_float: assert property (p_float) else $error("data driven while inhibited");

  property p_enable_wr;
    wr_go && wr_ix == `ORRD_IDX_RAM_CONTROL && wstrb_r[0] |=> ram_en == $past(wdata_r[7]);
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable write lost");

endmodule

`default_nettype wire

// ### dv/orrd_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

module orrd_cpu_model
  import orrd_pkg::*;
(
  // clock
  input  wire logic          aclk,
  // internal bus
  input  wire logic          cpu_ready,
  input  wire orrd_cpu_rsp_t cpu_rsp,
  output orrd_cpu_req_t      cpu_req
);

  initial cpu_req = '0;

  // ****************************************
  // one access, held until taken
  // ****************************************
  // take then count states to ack
  task automatic acc(input logic wr, input logic wd, input logic [15:0] a,
                     input logic [15:0] d, output orrd_cpu_rsp_t r, output int lat);
    int n;
    n = 0;
    lat = -1;
    r = '0;
    cpu_req <= '{valid: 1'b1, write: wr, word: wd, addr: a, wdata: d};
    do begin
      @(posedge aclk);
      n++;
    end while (cpu_ready !== 1'b1 && n < 50);
    // released bus shows the inverse, not the old value
    cpu_req <= '{valid: 1'b0, write: ~wr, word: ~wd, addr: ~a, wdata: ~d};
    for (int i = 1; i <= 4 && lat < 0; i++) begin
      @(posedge aclk);
      if (cpu_rsp.ack === 1'b1) begin
        r = cpu_rsp;
        // the take state counts as the first
        lat = i + 1;
      end
    end
  endtask

endmodule

`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "orrd_cfg.svh"

module tb
  import orrd_pkg::*;
;
  logic          aclk;
  logic          aresetn;
  orrd_cpu_req_t cpu_req;
  orrd_cpu_rsp_t cpu_rsp;
  orrd_cpu_rsp_t r;
  orrd_prom_in_t prom_in;
  logic          cpu_ready, prom_data_oe, prom_mode, irq, standby_pin;
  logic          port6_bit1_pin, port6_bit0_pin;
  logic [2:0]    mode_pins;
  logic [7:0]    prom_data_o;
  logic [17:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic          s_axi_rvalid, s_axi_rready;
  logic          rom_on;
  int            fail_count = 0;
  int            total_checks = 0;
  int            lat;

  orrd_top dut_u (.aclk, .aresetn, .cpu_req, .cpu_ready, .cpu_rsp, .mode_pins,
    .standby_pin, .port6_bit1_pin, .port6_bit0_pin, .prom_in, .prom_data_o,
    .prom_data_oe, .prom_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

  orrd_cpu_model cpu_u (.aclk, .cpu_ready, .cpu_rsp, .cpu_req);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ****************************************
  // report, compare, bounded wait
  // ****************************************
  task automatic final_report();
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100) begin
      chk("timeout", 36'h0, 36'h1);
      final_report();
    end
  endtask

  // ****************************************
  // axi4-lite master
  // ****************************************
  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d);
    int   n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", 36'h0, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [17:0] a, input logic [33:0] e);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk("axi read", e, {s_axi_rresp, s_axi_rdata});
    s_axi_rready <= 1'b0;
  endtask

  // ****************************************
  // cpu access with expected ext, error, data
  // ****************************************
  task automatic cpu(input logic wr, input logic wd, input logic [15:0] a,
                     input logic [15:0] d, input logic dv, input logic [17:0] e);
    cpu_u.acc(wr, wd, a, d, r, lat);
    chk("states", `ORRD_ACCESS_STATES, lat);
    chk("cpu rsp", e, {r.ext, r.addr_err, dv ? (wd ? r.rdata : {8'h00, r.rdata[7:0]}) : 16'h0});
  endtask

  task automatic rst(input logic [2:0] m, input logic s);
    aresetn <= 1'b0;
    mode_pins <= m;
    standby_pin <= s;
    port6_bit1_pin <= ~s;
    port6_bit0_pin <= ~s;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
  endtask

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    prom_in = '{ce_n: 1'b1, oe_n: 1'b1, addr: 15'h0000, data: 8'h00};
    rst(3'h7, 1'b1);
    chk("prom mode", 36'h0, prom_mode);
    axi_rd(18'h3ffe4, 34'h0ff);
    axi_rd(18'h00000, 34'h200000000);
    cpu(1'b1, 1'b1, 16'hfb80, 16'h1234, 1'b0, 18'h0);
    cpu(1'b1, 1'b1, 16'hff7e, 16'habcd, 1'b0, 18'h0);
    cpu(1'b0, 1'b0, 16'hfb81, 16'h0, 1'b1, 18'h00034);
    cpu(1'b0, 1'b1, 16'hff7e, 16'h0, 1'b1, 18'h0abcd);
    cpu(1'b0, 1'b1, 16'hfb80, 16'h0, 1'b1, 18'h01234);
    cpu(1'b1, 1'b0, 16'hfff9, 16'h0000, 1'b0, 18'h0);
    cpu(1'b0, 1'b0, 16'hfff9, 16'h0, 1'b1, 18'h0007f);
    axi_wr(18'h3ffc4, 32'h1);
    cpu(1'b1, 1'b0, 16'hfc00, 16'h0011, 1'b0, 18'h10000);
    repeat (2) @(posedge aclk);
    chk("irq set", 36'h1, irq);
    axi_rd(18'h3ffc0, 34'h1);
    @(posedge aclk);
    chk("irq clear", 36'h0, irq);
    axi_rd(18'h3ffc0, 34'h0);
    axi_wr(18'h3ffe4, 32'h80);
    axi_rd(18'h3ffe4, 34'h0ff);
    axi_wr(18'h3ffe4, 32'h7f);
    standby_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    standby_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(18'h3ffe4, 34'h07f);
    // modes 1 to 4 and 7, rom use and disabled ram window
    for (int i = 0; i < 5; i++) begin
      logic [2:0] m;
      m = (i == 4) ? 3'h7 : 3'(i + 1);
      rom_on = (m == 3'h2 || m == 3'h4 || m == 3'h7);
      rst(m, 1'b1);
      axi_rd(18'h3ffe4, 34'h0ff);
      axi_rd(18'h3ffc8, {28'h0, 6'h20 | {1'b0, rom_on, 1'b0, m}});
      cpu(1'b0, 1'b1, 16'h0000, 16'h0, 1'b0, {~rom_on, 17'h0});
      axi_wr(18'h3ffe4, 32'h0);
      cpu(1'b0, 1'b1, 16'hfb80, 16'h0, 1'b0, (m == 3'h7) ? 18'h10000 : 18'h20000);
      repeat (2) @(posedge aclk);
      chk("irq masked", 36'h0, irq);
      axi_rd(18'h3ffc0, (m == 3'h7) ? 34'h1 : 34'h2);
    end
    // programming pins
    rst(3'h0, 1'b0);
    chk("prog", 36'h2, {prom_mode, cpu_ready});
    prom_in <= '{ce_n: 1'b0, oe_n: 1'b1, addr: 15'h0003, data: 8'h5a};
    repeat (8) @(posedge aclk);
    prom_in <= '{ce_n: 1'b1, oe_n: 1'b0, addr: 15'h0003, data: 8'ha5};
    repeat (8) @(posedge aclk);
    chk("verify", 36'h15a, {prom_data_oe, prom_data_o});
    prom_in.oe_n <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("inhibit", 36'h0, prom_data_oe);
    final_report();
  end

endmodule

`default_nettype wire
